//--- inc/sarseq_pkg.sv
// Shared constants and types for the converter sequencer
// Overview of operation
// - Result right-justified, left when alignment set
// - Low byte read locks both result bytes
// - High byte read releases the lock
// - Done flag still set when result discarded
// - Start bit begins conversion, reads busy
// - Channel change waits for running conversion
// - Free running converts continuously after first start
// - Free running ignores uncleared done flag
// - Prescaler divides, held reset while disabled
// - Selections take effect only when enabled
// - Start at next prescaled clock rise
// - Thirteen cycles normal, twenty-five first
// - Sample at 1.5, 2.5 (14-cycle differential) or 13.5 cycles
// - Completion writes result, sets flag, clears start in single mode
// - Free running restarts immediately, start stays set
// - Differential user start 13 or 14 cycles
// - Automatic differential conversions take 14 cycles
// - Channel field picks input and gain
// - Selection buffer frozen during conversion
// - Buffer tracks again in final cycle
package sarseq_pkg;
	// Register byte addresses
	localparam logic [3:0] SARSEQ_CHANNEL_SELECT_REG_ADDR = 4'h0;
	localparam logic [3:0] SARSEQ_CONVERTER_CONTROL_STATUS_ADDR = 4'h4;
	localparam logic [3:0] SARSEQ_RESULT_LOW_BYTE_ADDR = 4'h8;
	localparam logic [3:0] SARSEQ_RESULT_HIGH_BYTE_ADDR = 4'hC;
	// channel_select_reg fields
	localparam int SARSEQ_REFERENCE_SELECT_LSB = 6;
	localparam int SARSEQ_RESULT_LEFT_ALIGN_BIT = 5;
	localparam int SARSEQ_INPUT_GAIN_SELECT_LSB = 0;
	// converter_control_status fields
	localparam int SARSEQ_CONVERTER_ENABLE_BIT = 7;
	localparam int SARSEQ_START_CONVERSION_BIT = 6;
	localparam int SARSEQ_FREE_RUNNING_SELECT_BIT = 5;
	localparam int SARSEQ_CONVERSION_DONE_FLAG_BIT = 4;
	localparam int SARSEQ_INTERRUPT_ENABLE_BIT = 3;
	localparam int SARSEQ_CLOCK_DIVIDE_SELECT_LSB = 0;
	// Reset values
	localparam logic [7:0] SARSEQ_CHANNEL_SELECT_RESET = 8'h00;
	localparam logic [7:0] SARSEQ_CONTROL_RESET = 8'h00;
	// Conversion lengths in converter clock cycles
	localparam logic [4:0] SARSEQ_NORMAL_CYCLES = 5'd13;
	localparam logic [4:0] SARSEQ_FIRST_CYCLES = 5'd25;
	localparam logic [4:0] SARSEQ_DIFF_SYNC_CYCLES = 5'd14;
	// Sample instant: falling edge in the middle of this cycle index (x.5 cycles)
	localparam logic [4:0] SARSEQ_NORMAL_SAMPLE_CYCLE = 5'd1;
	localparam logic [4:0] SARSEQ_FIRST_SAMPLE_CYCLE = 5'd13;
	localparam logic [4:0] SARSEQ_DIFF_SYNC_SAMPLE_CYCLE = 5'd2;
	localparam int SARSEQ_RESULT_BITS = 10;
	// AXI responses
	localparam logic [1:0] SARSEQ_RESP_OKAY = 2'b00;
	localparam logic [1:0] SARSEQ_RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		SARSEQ_GAIN_BYPASS,
		SARSEQ_GAIN_1X,
		SARSEQ_GAIN_10X,
		SARSEQ_GAIN_200X
	} sarseq_gain_t;

	// Selection applied to the analog side
	typedef struct packed {
		logic [1:0] reference_select;
		logic [4:0] input_gain_select;
	} sarseq_sel_t;
endpackage

//--- src/sarseq_core.sv
// Converter sequencer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module sarseq_core
	import sarseq_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Interrupt
	output logic irq_o,
	input wire logic irq_ack_i,
	// Analog core
	output logic conv_enable_o,
	output sarseq_sel_t conv_sel_o,
	output sarseq_gain_t conv_gain_o,
	output logic conv_start_o,
	output logic conv_sample_o,
	output logic conv_clk_o,
	input wire logic [9:0] conv_result_i
);

	typedef enum logic {
		SARSEQ_IDLE,
		SARSEQ_CONV
	} sarseq_state_t;

	// Maps the channel field onto the gain stage setting
	function automatic sarseq_gain_t gain_of(input logic [4:0] sel);
		if (sel[4:3] == 2'b00 || sel[4:1] == 4'hF) begin
			gain_of = SARSEQ_GAIN_BYPASS;
		end else if (sel[4:2] == 3'b010) begin
			gain_of = SARSEQ_GAIN_10X;
		end else if (sel[4:2] == 3'b011) begin
			gain_of = SARSEQ_GAIN_200X;
		end else begin
			gain_of = SARSEQ_GAIN_1X;
		end
	endfunction

	// Prescale ratio; eight bits so that the divide-by-128 setting still fits
	function automatic logic [7:0] ratio_of(input logic [2:0] ps);
		ratio_of = (ps == 3'd0) ? 8'd2 : (8'd1 << ps);
	endfunction

	logic [7:0] chan_r;
	logic [7:0] ctrl_r;
	logic [7:0] res_lo_r;
	logic [7:0] res_hi_r;
	logic lock_r;
	sarseq_sel_t sel_buf_r;
	sarseq_state_t state_r;
	logic [6:0] pre_cnt_r;
	logic conv_clk_r;
	logic half_r;
	logic first_r;
	logic pend_r;
	logic [4:0] cyc_r;
	logic [4:0] len_r;
	logic [4:0] samp_r;
	logic start_r;
	logic sample_r;
	logic aw_hold_r;
	logic [3:0] aw_addr_r;
	logic w_hold_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	logic enable;
	logic free_run;
	logic [7:0] ratio;
	logic run;
	logic rise;
	logic fall;
	logic finish;
	logic tracking;
	logic diff_sel;
	logic wr_do;
	logic rd_do;
	logic wr_ctrl;
	logic wr_chan;
	logic [7:0] wbyte;
	logic [15:0] aligned;

	assign enable = ctrl_r[SARSEQ_CONVERTER_ENABLE_BIT];
	assign free_run = ctrl_r[SARSEQ_FREE_RUNNING_SELECT_BIT];
	assign ratio = ratio_of(ctrl_r[SARSEQ_CLOCK_DIVIDE_SELECT_LSB +: 3]);
	assign rise = ce_i && enable && ({1'b0, pre_cnt_r} == ratio - 8'd1);
	assign fall = ce_i && enable && ({1'b0, pre_cnt_r} == (ratio >> 1) - 8'd1);
	// A disabling write stops the converter at that same edge, so no start,
	// sample or clock edge escapes while the enable output is already low
	assign run = enable && !(wr_ctrl && !wbyte[SARSEQ_CONVERTER_ENABLE_BIT]);
	assign finish = rise && state_r == SARSEQ_CONV && cyc_r == len_r - 5'd1;
	assign tracking = state_r == SARSEQ_IDLE || cyc_r == len_r - 5'd1;
	assign diff_sel = gain_of(sel_buf_r.input_gain_select) != SARSEQ_GAIN_BYPASS;

	// Write happens once address and data are both held
	assign wr_do = aw_hold_r && w_hold_r && !bvalid_r;
	assign rd_do = s_axi_arvalid_i && !rvalid_r;
	assign wbyte = w_data_r[7:0];
	assign wr_ctrl = ce_i && wr_do && w_strb_r[0] && aw_addr_r == SARSEQ_CONVERTER_CONTROL_STATUS_ADDR;
	assign wr_chan = ce_i && wr_do && w_strb_r[0] && aw_addr_r == SARSEQ_CHANNEL_SELECT_REG_ADDR;

	assign s_axi_awready_o = ce_i && !aw_hold_r;
	assign s_axi_wready_o = ce_i && !w_hold_r;
	assign s_axi_arready_o = ce_i && !rvalid_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rresp_o = rresp_r;
	assign s_axi_rdata_o = rdata_r;

	assign irq_o = ctrl_r[SARSEQ_CONVERSION_DONE_FLAG_BIT] && ctrl_r[SARSEQ_INTERRUPT_ENABLE_BIT];
	assign conv_enable_o = enable;
	assign conv_sel_o = sel_buf_r;
	assign conv_gain_o = gain_of(sel_buf_r.input_gain_select);
	assign conv_start_o = start_r;
	assign conv_sample_o = sample_r;
	assign conv_clk_o = conv_clk_r;

	// Justified result for the two data bytes
	assign aligned = chan_r[SARSEQ_RESULT_LEFT_ALIGN_BIT] ?
		{conv_result_i, 6'h00} : {6'h00, conv_result_i};

	// AXI write channel capture
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_hold_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= SARSEQ_RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && !aw_hold_r) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr_i[3:2], 2'b00};
			end
			if (s_axi_wvalid_i && !w_hold_r) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			if (wr_do) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (aw_addr_r == SARSEQ_CHANNEL_SELECT_REG_ADDR ||
					aw_addr_r == SARSEQ_CONVERTER_CONTROL_STATUS_ADDR ||
					aw_addr_r == SARSEQ_RESULT_LOW_BYTE_ADDR ||
					aw_addr_r == SARSEQ_RESULT_HIGH_BYTE_ADDR) ?
					SARSEQ_RESP_OKAY : SARSEQ_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// AXI read channel; reads of the result bytes steer the lock
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rvalid_r <= 1'b0;
			rresp_r <= SARSEQ_RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else if (ce_i) begin
			if (rd_do) begin
				rvalid_r <= 1'b1;
				rresp_r <= SARSEQ_RESP_OKAY;
				case ({s_axi_araddr_i[3:2], 2'b00})
					SARSEQ_CHANNEL_SELECT_REG_ADDR: rdata_r <= {24'h000000, chan_r};
					SARSEQ_CONVERTER_CONTROL_STATUS_ADDR: rdata_r <= {24'h000000, ctrl_r};
					SARSEQ_RESULT_LOW_BYTE_ADDR: rdata_r <= {24'h000000, res_lo_r};
					SARSEQ_RESULT_HIGH_BYTE_ADDR: rdata_r <= {24'h000000, res_hi_r};
					default: begin
						rdata_r <= 32'h00000000;
						rresp_r <= SARSEQ_RESP_SLVERR;
					end
				endcase
			end else if (rvalid_r && s_axi_rready_i) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Software copy of the channel selection
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			chan_r <= SARSEQ_CHANNEL_SELECT_RESET;
		end else if (wr_chan) begin
			chan_r <= wbyte;
		end
	end

	// Buffered selection follows software only when safe and enabled
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sel_buf_r <= '0;
		end else if (ce_i && enable && tracking) begin
			sel_buf_r.reference_select <= chan_r[SARSEQ_REFERENCE_SELECT_LSB +: 2];
			sel_buf_r.input_gain_select <= chan_r[SARSEQ_INPUT_GAIN_SELECT_LSB +: 5];
		end
	end

	// Control and status byte; hardware set of the flag beats the clear
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_r <= SARSEQ_CONTROL_RESET;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				ctrl_r[SARSEQ_CONVERTER_ENABLE_BIT] <= wbyte[SARSEQ_CONVERTER_ENABLE_BIT];
				ctrl_r[SARSEQ_FREE_RUNNING_SELECT_BIT] <= wbyte[SARSEQ_FREE_RUNNING_SELECT_BIT];
				ctrl_r[SARSEQ_INTERRUPT_ENABLE_BIT] <= wbyte[SARSEQ_INTERRUPT_ENABLE_BIT];
				ctrl_r[SARSEQ_CLOCK_DIVIDE_SELECT_LSB +: 3] <=
					wbyte[SARSEQ_CLOCK_DIVIDE_SELECT_LSB +: 3];
				if (wbyte[SARSEQ_CONVERSION_DONE_FLAG_BIT]) begin
					ctrl_r[SARSEQ_CONVERSION_DONE_FLAG_BIT] <= 1'b0;
				end
			end
			if (irq_ack_i) begin
				ctrl_r[SARSEQ_CONVERSION_DONE_FLAG_BIT] <= 1'b0;
			end
			// Start only sets; a zero write leaves it alone
			if (wr_ctrl && wbyte[SARSEQ_START_CONVERSION_BIT] &&
				wbyte[SARSEQ_CONVERTER_ENABLE_BIT]) begin
				ctrl_r[SARSEQ_START_CONVERSION_BIT] <= 1'b1;
			end
			if (finish) begin
				ctrl_r[SARSEQ_CONVERSION_DONE_FLAG_BIT] <= 1'b1;
				if (!free_run) begin
					ctrl_r[SARSEQ_START_CONVERSION_BIT] <= 1'b0;
				end
			end
			// Disabling aborts and clears a pending start
			if (wr_ctrl && !wbyte[SARSEQ_CONVERTER_ENABLE_BIT]) begin
				ctrl_r[SARSEQ_START_CONVERSION_BIT] <= 1'b0;
			end
		end
	end

	// Prescaler and the converter clocks
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pre_cnt_r <= 7'd0;
			conv_clk_r <= 1'b0;
			half_r <= 1'b0;
		end else if (ce_i) begin
			if (!run) begin
				pre_cnt_r <= 7'd0;
				conv_clk_r <= 1'b0;
				half_r <= 1'b0;
			end else begin
				pre_cnt_r <= rise ? 7'd0 : pre_cnt_r + 7'd1;
				if (rise) begin
					conv_clk_r <= 1'b1;
					half_r <= !half_r;
				end else if (fall) begin
					conv_clk_r <= 1'b0;
				end
			end
		end
	end

	// Result bytes with read-order lock
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			res_lo_r <= 8'h00;
			res_hi_r <= 8'h00;
			lock_r <= 1'b0;
		end else if (ce_i) begin
			if (finish && !lock_r) begin
				res_lo_r <= aligned[7:0];
				res_hi_r <= aligned[15:8];
			end
			if (rd_do && s_axi_araddr_i[3:2] == SARSEQ_RESULT_LOW_BYTE_ADDR[3:2]) begin
				lock_r <= 1'b1;
			end else if (rd_do && s_axi_araddr_i[3:2] == SARSEQ_RESULT_HIGH_BYTE_ADDR[3:2]) begin
				lock_r <= 1'b0;
			end
		end
	end

	// Conversion sequencer
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= SARSEQ_IDLE;
			first_r <= 1'b1;
			pend_r <= 1'b0;
			cyc_r <= 5'd0;
			len_r <= SARSEQ_FIRST_CYCLES;
			samp_r <= SARSEQ_FIRST_SAMPLE_CYCLE;
			start_r <= 1'b0;
			sample_r <= 1'b0;
		end else if (ce_i) begin
			start_r <= 1'b0;
			sample_r <= run && fall && state_r == SARSEQ_CONV && cyc_r == samp_r;
			if (!run) begin
				state_r <= SARSEQ_IDLE;
				first_r <= 1'b1;
				// Enable and start written together still arm the first conversion
				pend_r <= wr_ctrl && wbyte[SARSEQ_START_CONVERSION_BIT] &&
					wbyte[SARSEQ_CONVERTER_ENABLE_BIT];
				cyc_r <= 5'd0;
			end else begin
				if (wr_ctrl && wbyte[SARSEQ_START_CONVERSION_BIT] && state_r == SARSEQ_IDLE) begin
					pend_r <= 1'b1;
				end
				case (state_r)
					SARSEQ_IDLE: begin
						if (rise && pend_r) begin
							state_r <= SARSEQ_CONV;
							pend_r <= 1'b0;
							start_r <= 1'b1;
							cyc_r <= 5'd0;
							if (first_r) begin
								len_r <= SARSEQ_FIRST_CYCLES;
								samp_r <= SARSEQ_FIRST_SAMPLE_CYCLE;
							end else if (diff_sel && half_r) begin
								len_r <= SARSEQ_DIFF_SYNC_CYCLES;
								samp_r <= SARSEQ_DIFF_SYNC_SAMPLE_CYCLE;
							end else begin
								len_r <= SARSEQ_NORMAL_CYCLES;
								samp_r <= SARSEQ_NORMAL_SAMPLE_CYCLE;
							end
							first_r <= 1'b0;
						end
					end
					SARSEQ_CONV: begin
						if (finish) begin
							// Free running ignores the done flag entirely
							if (free_run) begin
								start_r <= 1'b1;
								cyc_r <= 5'd0;
								if (diff_sel) begin
									len_r <= SARSEQ_DIFF_SYNC_CYCLES;
									samp_r <= SARSEQ_DIFF_SYNC_SAMPLE_CYCLE;
								end else begin
									len_r <= SARSEQ_NORMAL_CYCLES;
									samp_r <= SARSEQ_NORMAL_SAMPLE_CYCLE;
								end
							end else begin
								// Single mode waits for the next software start
								state_r <= SARSEQ_IDLE;
							end
						end else if (rise) begin
							cyc_r <= cyc_r + 5'd1;
						end
					end
					default: state_r <= SARSEQ_IDLE;
				endcase
			end
		end
	end

endmodule // sarseq_core

//--- test/sarseq_core_model.sv
// Behavioural analog core that returns a new random code for every conversion
`timescale 1ns/1ps
module sarseq_core_model (
	// Core side
	input wire logic ref_clk_i,
	input wire logic conv_start_i,
	input wire logic conv_enable_i,
	output logic [9:0] conv_result_o,
	output logic [9:0] held_o
);
	integer seed = 32'h163D10AB;
	always @(posedge ref_clk_i) begin
		if (conv_start_i) held_o <= 10'($random(seed));
	end
	// A powered-down core carries no code, so show a changed value
	assign conv_result_o = conv_enable_i ? held_o : ~held_o;
endmodule // sarseq_core_model

//--- test/sarseq_core_props.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module sarseq_core_props
	import sarseq_pkg::*;
(
	// Clock and bus
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic [31:0] s_axi_rdata_o,
	// Analog side
	input wire logic conv_enable_o,
	input wire sarseq_sel_t conv_sel_o,
	input wire sarseq_gain_t conv_gain_o,
	input wire logic conv_start_o,
	input wire logic conv_sample_o,
	input wire logic conv_clk_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	property p_clk_off;
		!conv_enable_o |-> !conv_clk_o;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock runs while off");
	property p_start_en;
		conv_start_o |-> conv_enable_o;
	endproperty
	a_start_en: assert property (p_start_en) else $error("start while off");
	property p_sel_hold;
		conv_start_o |=> $stable(conv_sel_o)[*8];
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection moved");
	property p_gap;
		conv_start_o |=> !conv_start_o[*8];
	endproperty
	a_gap: assert property (p_gap) else $error("conversion too short");
	property p_bypass;
		conv_sel_o.input_gain_select[4:3] == 2'h0 |-> conv_gain_o == SARSEQ_GAIN_BYPASS;
	endproperty
	a_bypass: assert property (p_bypass) else $error("gain not bypassed");
	property p_g10;
		conv_sel_o.input_gain_select[4:2] == 3'h2 |-> conv_gain_o == SARSEQ_GAIN_10X;
	endproperty
	a_g10: assert property (p_g10) else $error("gain not 10x");
	property p_g200;
		conv_sel_o.input_gain_select[4:2] == 3'h3 |-> conv_gain_o == SARSEQ_GAIN_200X;
	endproperty
	a_g200: assert property (p_g200) else $error("gain not 200x");
	property p_smp;
		conv_sample_o |-> conv_enable_o && !conv_start_o && !$past(conv_start_o);
	endproperty
	a_smp: assert property (p_smp) else $error("sample misplaced");
	property p_ce;
		!ce_i |-> !s_axi_awready_o && !s_axi_wready_o && !s_axi_arready_o;
	endproperty
	a_ce: assert property (p_ce) else $error("ready while frozen");
	property p_rd_hi;
		s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
endmodule // sarseq_core_props
bind sarseq_core sarseq_core_props chk (.*);

//--- test/sar_adc_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_bench;
	import sarseq_pkg::*;
	logic ref_clk_i = 1'h0, reset_i = 1'h1, ce_i = 1'h1, irq_ack_i = 1'h0;
	logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic irq_o, conv_enable_o, conv_start_o, conv_sample_o, conv_clk_o, irq_q;
	sarseq_sel_t conv_sel_o;
	sarseq_gain_t conv_gain_o;
	logic [9:0] conv_result_i, res, x;
	int fail_count = 0, samples_checked = 0, cyc = 0, ts, tp, tsm, td, t1, s1, t2;
	integer seed = 32'h163D10AB;
	logic [31:0] eq[$], mq[$];
	sarseq_core uut (.*);
	sarseq_core_model far (.ref_clk_i, .conv_start_i(conv_start_o),
		.conv_enable_i(conv_enable_o), .conv_result_o(conv_result_i), .held_o(res));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h0, d};
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		tb = 1'h0;
		while (!tb) begin
			@(negedge ref_clk_i);
			ta = s_axi_awvalid_i && s_axi_awready_o;
			tw = s_axi_wvalid_i && s_axi_wready_o;
			tb = s_axi_bvalid_o;
			@(posedge ref_clk_i);
			if (ta) s_axi_awvalid_i <= 1'h0;
			if (tw) s_axi_wvalid_i <= 1'h0;
		end
		s_axi_bready_i <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
		logic ta, tr;
		eq.push_back(e & m);
		mq.push_back(m);
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		tr = 1'h0;
		while (!tr) begin
			@(negedge ref_clk_i);
			ta = s_axi_arvalid_i && s_axi_arready_o;
			tr = s_axi_rvalid_o;
			@(posedge ref_clk_i);
			if (ta) s_axi_arvalid_i <= 1'h0;
		end
		s_axi_rready_i <= 1'h0;
	endtask
	task automatic done();
		wait (irq_o === 1'h1);
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	task automatic ack();
		@(posedge ref_clk_i);
		irq_ack_i <= 1'h1;
		@(posedge ref_clk_i);
		irq_ack_i <= 1'h0;
		@(negedge ref_clk_i);
		chk(irq_o, 1'h0, "irq after service");
	endtask
	task automatic starts(input int n);
		repeat (n) @(posedge conv_start_o);
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	// Read-data and response checker fed by the drivers' notes
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		irq_q <= irq_o;
		if (conv_start_o) begin
			tp <= ts;
			ts <= cyc;
		end
		if (conv_sample_o) tsm <= cyc;
		if (irq_o && !irq_q) td <= cyc;
		if (s_axi_rvalid_o && s_axi_rready_i) begin
			chk(s_axi_rdata_o & mq.pop_front(), eq.pop_front(), "read data");
			chk(s_axi_rresp_o, SARSEQ_RESP_OKAY, "read resp");
		end
		if (s_axi_bvalid_o && s_axi_bready_i) chk(s_axi_bresp_o, SARSEQ_RESP_OKAY, "write resp");
		if (cyc > 40000) begin
			chk(0, 1, "timeout");
			complete_run();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		reset_i <= 1'h0;
		rd(4'h0, 32'h0, 32'hFF);
		rd(4'h4, 32'h0, 32'hFF);
		wr(4'h0, 8'h0C);
		repeat (4) @(posedge ref_clk_i);
		chk(32'(conv_sel_o), 32'h0, "selection while off");
		wr(4'h4, 8'h88);
		@(negedge ref_clk_i);
		chk(32'(conv_sel_o), 32'hC, "selection when on");
		chk(32'(conv_gain_o), 32'(SARSEQ_GAIN_200X), "gain");
		chk(conv_enable_o, 1'h1, "enable output");
		@(posedge ref_clk_i);
		ce_i <= 1'h0;
		repeat (3) @(posedge ref_clk_i);
		ce_i <= 1'h1;
		wr(4'h0, 8'h03);
		wr(4'h4, 8'hC8);
		rd(4'h4, 32'h40, 32'h40);
		wr(4'h0, 8'h05);
		chk(32'(conv_sel_o), 32'h3, "selection kept");
		done();
		t1 = td - ts;
		s1 = tsm - ts;
		chk(32'(conv_sel_o), 32'h5, "selection after end");
		rd(4'h4, 32'h98, 32'hFF);
		rd(4'h8, {24'h0, res[7:0]}, 32'hFF);
		rd(4'hC, {30'h0, res[9:8]}, 32'hFF);
		ack();
		$display("test first conversion done");
		wr(4'h4, 8'hC8);
		done();
		t2 = td - ts;
		chk(t1 - t2, 24, "first minus normal length");
		chk(s1 - (tsm - ts), 24, "sample offset");
		x = res;
		rd(4'h8, {24'h0, x[7:0]}, 32'hFF);
		wr(4'h4, 8'h98);
		@(negedge ref_clk_i);
		chk(irq_o, 1'h0, "flag write clear");
		wr(4'h4, 8'hC8);
		wr(4'h4, 8'h88);
		done();
		rd(4'h8, {24'h0, x[7:0]}, 32'hFF);
		rd(4'hC, {30'h0, x[9:8]}, 32'hFF);
		ack();
		wr(4'h0, 8'h25);
		wr(4'h4, 8'hC8);
		done();
		ack();
		rd(4'hC, {24'h0, res[9:2]}, 32'hFF);
		rd(4'h8, {24'h0, res[1:0], 6'h0}, 32'hFF);
		$display("test lock done");
		wr(4'h0, 8'h08);
		wr(4'h4, 8'hC8);
		done();
		chk((td - ts - t2 == 0) || (td - ts - t2 == 2), 1, "differential length");
		ack();
		for (int k = 0; k < 4; k++) begin
			int r;
			r = (k == 0) ? 2 : (1 << k);
			wr(4'h4, 8'h00);
			wr(4'h0, 8'($random(seed)) & 8'hC7);
			wr(4'h4, 8'hA0 | 8'(k));
			wr(4'h4, 8'hE0 | 8'(k));
			starts(2);
			chk(ts - tp, 25 * r, "first free-running length");
			starts(1);
			chk(ts - tp, 13 * r, "free-running period");
			rd(4'h4, 32'h50, 32'h50);
		end
		$display("test free running done");
		wr(4'h4, 8'h00);
		wr(4'h0, 8'h09);
		wr(4'h4, 8'hA0);
		wr(4'h4, 8'hE0);
		starts(3);
		chk(ts - tp, 28, "differential free-running period");
		wr(4'h4, 8'h00);
		$display("test differential done");
		complete_run();
	end
endmodule // sar_adc_sequencer_bench
